// [rtl/ifr_top.sv]
// event flag registers, enables and pin selects of the converter data path
`timescale 1ns/1ps
`include "ifr_map.svh"

// What this block does
// - A failed parity check on incoming data sets bit 7 of the upper flag register.
// - A mismatch from the sample error detection compare sets bit 6 of the upper flags.
// - A warning from the data interface delay-locked loop sets bit 5 of the upper flags.
// - Lock of the data interface delay-locked loop sets bit 4 of the upper flags.
// - The buffer read pointer catching the write pointer sets bit 2, buffer underflow.
// - The write pointer colliding with the read pointer sets bit 1, buffer overflow.
// - A buffer fill of one slot or less, or six slots or more, sets bit 0, buffer warning.
// - The upper flag register resets to zero and the host can only read it.
// - An event whose pin select bit is zero, the reset value, goes to the first pin.
// - An event whose pin select bit is one goes to the second pin instead.
// - An event reaches its pin only while its enable bit is set; enables reset to zero.
// - Loss of sync and lock of sync set their own flags, routed by the lower select.
module ifr_top
    import ifr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic parity_fail_evt,
    input wire logic sample_error_evt,
    input wire logic loop_warning_evt,
    input wire logic loop_locked_evt,
    input wire logic sync_lost_evt,
    input wire logic sync_locked_evt,
    input wire logic [IFR_PTR_W-1:0] buf_wr_ptr,
    input wire logic [IFR_PTR_W-1:0] buf_rd_ptr,
    output logic interrupt_pin_a,
    output logic interrupt_pin_b
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (IFR_PTR_W < 3) begin : g_bad_ptr
        $error("buffer pointers too narrow for the warning thresholds");
    end

    if (IFR_N_EVT != 16) begin : g_bad_evt
        $error("router width must match the two eight-bit flag registers");
    end

    // both thresholds must be reachable by a pointer difference
    if (`IFR_WARN_HI >= (1 << IFR_PTR_W) || `IFR_WARN_LO >= `IFR_WARN_HI) begin : g_bad_warn
        $error("buffer warning thresholds do not fit the pointer range");
    end

    localparam logic [IFR_PTR_W-1:0] WARN_LO = IFR_PTR_W'(`IFR_WARN_LO);
    localparam logic [IFR_PTR_W-1:0] WARN_HI = IFR_PTR_W'(`IFR_WARN_HI);

    // ----------------------------------------
    // state
    // ----------------------------------------
    ifr_top_state_t st;
    ifr_top_state_t next_st;

    // ----------------------------------------
    // buffer pointer watch
    // ----------------------------------------
    logic [IFR_PTR_W-1:0] fill;
    logic ptr_equal;
    logic rd_moved;
    logic wr_moved;
    logic underflow_hit;
    logic overflow_hit;
    logic buf_warn_hit;
    logic warn_low;
    logic warn_high;

    // fill wraps modulo the pointer range; equal pointers read as empty
    assign fill = buf_wr_ptr - buf_rd_ptr;
    assign ptr_equal = (buf_wr_ptr == buf_rd_ptr);
    assign rd_moved = (buf_rd_ptr != st.rd_prev);
    assign wr_moved = (buf_wr_ptr != st.wr_prev);

    // a move onto the other pointer tells who caught whom
    assign underflow_hit = ptr_equal & rd_moved;
    assign overflow_hit = ptr_equal & wr_moved & ~rd_moved;
    assign warn_low = (fill <= WARN_LO);
    assign warn_high = (fill >= WARN_HI);
    assign buf_warn_hit = warn_low | warn_high;

    // ----------------------------------------
    // event vectors
    // ----------------------------------------
    logic [7:0] ev_upper;
    logic [7:0] ev_lower;

    always_comb begin
        ev_upper = 8'h00;
        ev_upper[`IFR_B_PARITY] = parity_fail_evt;
        ev_upper[`IFR_B_SAMPLE_ERR] = sample_error_evt;
        ev_upper[`IFR_B_LOOP_WARN] = loop_warning_evt;
        ev_upper[`IFR_B_LOOP_LOCK] = loop_locked_evt;
        ev_upper[`IFR_B_UNDERFLOW] = underflow_hit;
        ev_upper[`IFR_B_OVERFLOW] = overflow_hit;
        ev_upper[`IFR_B_BUF_WARN] = buf_warn_hit;
        ev_lower = 8'h00;
        ev_lower[`IFR_B_SYNC_LOST] = sync_lost_evt;
        ev_lower[`IFR_B_SYNC_LOCK] = sync_locked_evt;
    end

    // ----------------------------------------
    // register access decode
    // ----------------------------------------
    logic wr_en0;
    logic wr_en1;
    logic wr_sel0;
    logic wr_sel1;
    logic clr_lower;
    logic clr_upper;

    assign wr_en0 = reg_wr & (reg_addr == `IFR_OFS_EN0);
    assign wr_en1 = reg_wr & (reg_addr == `IFR_OFS_EN1);
    assign wr_sel0 = reg_wr & (reg_addr == `IFR_OFS_SEL0);
    assign wr_sel1 = reg_wr & (reg_addr == `IFR_OFS_SEL1);
    // flags clear on read so a level that persists shows up again
    assign clr_lower = reg_rd & (reg_addr == `IFR_OFS_FLAG0);
    assign clr_upper = reg_rd & (reg_addr == `IFR_OFS_FLAG1);

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [7:0] rd_value;

    always_comb begin
        unique case (reg_addr)
            `IFR_OFS_EN0: rd_value = st.en0;
            `IFR_OFS_EN1: rd_value = st.en1;
            `IFR_OFS_FLAG0: rd_value = st.flag0;
            `IFR_OFS_FLAG1: rd_value = st.flag1;
            `IFR_OFS_SEL0: rd_value = st.sel0;
            `IFR_OFS_SEL1: rd_value = st.sel1;
            default: rd_value = 8'h00;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.wr_prev = buf_wr_ptr;
        next_st.rd_prev = buf_rd_ptr;

        // set wins over the clear of the same cycle, so no event is lost
        next_st.flag1 = ((st.flag1 & ~{8{clr_upper}}) | ev_upper) & `IFR_MASK_HIGH;
        next_st.flag0 = ((st.flag0 & ~{8{clr_lower}}) | ev_lower) & `IFR_MASK_FLAG0;

        // the flag registers take no write at all
        if (wr_en0) begin
            next_st.en0 = reg_wdata & `IFR_MASK_LOW;
        end
        if (wr_en1) begin
            next_st.en1 = reg_wdata & `IFR_MASK_HIGH;
        end
        if (wr_sel0) begin
            next_st.sel0 = reg_wdata & `IFR_MASK_LOW;
        end
        if (wr_sel1) begin
            next_st.sel1 = reg_wdata & `IFR_MASK_HIGH;
        end

        if (reg_rd) begin
            next_st.rdata = rd_value;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st.en0 <= `IFR_RST_EN0;
            st.en1 <= `IFR_RST_EN1;
            st.sel0 <= `IFR_RST_SEL0;
            st.sel1 <= `IFR_RST_SEL1;
            st.flag0 <= `IFR_RST_FLAG0;
            st.flag1 <= `IFR_RST_FLAG1;
            st.rdata <= `IFR_RST_RDATA;
            // history follows the pointers so release sees no false move
            st.wr_prev <= buf_wr_ptr;
            st.rd_prev <= buf_rd_ptr;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;

    // ----------------------------------------
    // pin routing
    // ----------------------------------------
    ifr_route_if #(.N(IFR_N_EVT)) route ();

    // flags, enables and selects line up bit for bit in {upper, lower}
    assign route.flags = {st.flag1, st.flag0};
    assign route.enables = {st.en1, st.en0};
    assign route.selects = {st.sel1, st.sel0};

    ifr_router #(
        .N(IFR_N_EVT)
    ) u_router (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .route(route.rte)
    );

    // pins lag the flags by one cycle; cheap and glitch free
    assign interrupt_pin_a = route.pin_a;
    assign interrupt_pin_b = route.pin_b;

endmodule

// [rtl/ifr_map.svh]
// register offsets, bit positions, reset values and thresholds of the flag block
`ifndef IFR_MAP_SVH
`define IFR_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IFR_OFS_EN0 8'h03
`define IFR_OFS_EN1 8'h04
`define IFR_OFS_FLAG0 8'h05
`define IFR_OFS_FLAG1 8'h06
`define IFR_OFS_SEL0 8'h07
`define IFR_OFS_SEL1 8'h08

// ----------------------------------------
// reset values
// ----------------------------------------
`define IFR_RST_EN0 8'h00
`define IFR_RST_EN1 8'h00
`define IFR_RST_FLAG0 8'h00
`define IFR_RST_FLAG1 8'h00
`define IFR_RST_SEL0 8'h00
`define IFR_RST_SEL1 8'h00
`define IFR_RST_RDATA 8'h00

// ----------------------------------------
// implemented bits per register
// ----------------------------------------
`define IFR_MASK_LOW 8'h7f
`define IFR_MASK_HIGH 8'hf7
`define IFR_MASK_FLAG0 8'h60

// ----------------------------------------
// bit positions
// ----------------------------------------
`define IFR_B_PARITY 7
`define IFR_B_SAMPLE_ERR 6
`define IFR_B_LOOP_WARN 5
`define IFR_B_LOOP_LOCK 4
`define IFR_B_UNDERFLOW 2
`define IFR_B_OVERFLOW 1
`define IFR_B_BUF_WARN 0
`define IFR_B_SYNC_LOST 6
`define IFR_B_SYNC_LOCK 5

// ----------------------------------------
// buffer fill thresholds, in slots
// ----------------------------------------
`define IFR_WARN_LO 1
`define IFR_WARN_HI 6

`endif

// [rtl/ifr_pkg.sv]
// types shared by the flag block and its pin router
package ifr_pkg;

    localparam int IFR_PTR_W = 3;
    localparam int IFR_N_EVT = 16;

    typedef struct packed {
        logic [7:0] en0;
        logic [7:0] en1;
        logic [7:0] sel0;
        logic [7:0] sel1;
        logic [7:0] flag0;
        logic [7:0] flag1;
        logic [7:0] rdata;
        logic [IFR_PTR_W-1:0] wr_prev;
        logic [IFR_PTR_W-1:0] rd_prev;
    } ifr_top_state_t;

    typedef struct packed {
        logic pin_a;
        logic pin_b;
    } ifr_route_state_t;

endpackage

// [rtl/ifr_route_if.sv]
// flags, enables and pin selects passed from the flag block to the pin router
`timescale 1ns/1ps
interface ifr_route_if #(parameter int N = 16);
    logic [N-1:0] flags;
    logic [N-1:0] enables;
    logic [N-1:0] selects;
    logic pin_a;
    logic pin_b;

    modport src (output flags, output enables, output selects, input pin_a, input pin_b);
    modport rte (input flags, input enables, input selects, output pin_a, output pin_b);
endinterface

// [rtl/ifr_router.sv]
// steers enabled event flags onto the two interrupt pins
`timescale 1ns/1ps
module ifr_router
    import ifr_pkg::*;
#(
    parameter int N = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    ifr_route_if.rte route
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (N < 1) begin : g_bad_n
        $error("ifr_router needs at least one event");
    end

    // ----------------------------------------
    // per-event steering
    // ----------------------------------------
    logic [N-1:0] to_a;
    logic [N-1:0] to_b;

    for (genvar i = 0; i < N; i++) begin : g_evt
        assign to_a[i] = route.flags[i] & route.enables[i] & ~route.selects[i];
        assign to_b[i] = route.flags[i] & route.enables[i] & route.selects[i];
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    ifr_route_state_t st;
    ifr_route_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.pin_a = |to_a;
        next_st.pin_b = |to_b;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st.pin_a <= 1'b0;
            st.pin_b <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign route.pin_a = st.pin_a;
    assign route.pin_b = st.pin_b;

endmodule

// [testbench/ifr_chk.sv]
// port-level assertions for the event flag block
`timescale 1ns/1ps
`include "ifr_map.svh"
module ifr_chk
    import ifr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic parity_fail_evt,
    input wire logic sample_error_evt,
    input wire logic loop_warning_evt,
    input wire logic loop_locked_evt,
    input wire logic sync_lost_evt,
    input wire logic sync_locked_evt,
    input wire logic [IFR_PTR_W-1:0] buf_wr_ptr,
    input wire logic [IFR_PTR_W-1:0] buf_rd_ptr,
    input wire logic interrupt_pin_a,
    input wire logic interrupt_pin_b
);
    logic [7:0] en0, en1, sel0, sel1;
    // ----------------------------------------
    // shadow of enables and selects, seen through writes only
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en0 <= 8'h00;
            en1 <= 8'h00;
            sel0 <= 8'h00;
            sel1 <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                `IFR_OFS_EN0: en0 <= reg_wdata & `IFR_MASK_LOW;
                `IFR_OFS_EN1: en1 <= reg_wdata & `IFR_MASK_HIGH;
                `IFR_OFS_SEL0: sel0 <= reg_wdata & `IFR_MASK_LOW;
                `IFR_OFS_SEL1: sel1 <= reg_wdata & `IFR_MASK_HIGH;
                default: ;
            endcase
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_rst; $rose(rst_n) |-> reg_rdata == 8'h00 && !interrupt_pin_a && !interrupt_pin_b;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_rd_sel; reg_rd && !reg_wr && reg_addr == `IFR_OFS_SEL0 |=> reg_rdata == sel0;
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("select readback wrong");
    property p_rd_hold; !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmap; reg_rd && !(reg_addr inside {[8'h03:8'h08]}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    // three cycles because pins lag enables by a register stage
    property p_quiet; (en0 == 8'h00 && en1 == 8'h00) [*3] |-> !interrupt_pin_a && !interrupt_pin_b;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pin up with all disabled");
    property p_selz; ((sel0 | sel1) == 8'h00) [*3] |-> !interrupt_pin_b;
    endproperty
    a_selz: assert property (p_selz) else $error("second pin used unselected");
    property p_par_b; parity_fail_evt && en1[7] && sel1[7] && !reg_wr ##1 !reg_wr |-> ##1 interrupt_pin_b;
    endproperty
    a_par_b: assert property (p_par_b) else $error("parity not on second pin");
    property p_sed_a; sample_error_evt && en1[6] && !sel1[6] && !reg_wr ##1 !reg_wr |-> ##1 interrupt_pin_a;
    endproperty
    a_sed_a: assert property (p_sed_a) else $error("sample error not on first pin");
    property p_sync_b; sync_lost_evt && en0[6] && sel0[6] && !reg_wr ##1 !reg_wr |-> ##1 interrupt_pin_b;
    endproperty
    a_sync_b: assert property (p_sync_b) else $error("sync loss not on second pin");
    property p_sync_a; sync_locked_evt && en0[5] && !sel0[5] && !reg_wr ##1 !reg_wr |-> ##1 interrupt_pin_a;
    endproperty
    a_sync_a: assert property (p_sync_a) else $error("sync lock not on first pin");
endmodule

// [testbench/ifr_host.sv]
// host model: register port cycles and interrupt servicing
`timescale 1ns/1ps
module ifr_host (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse so stale values never pass for live ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        q = reg_rdata;
    endtask
    // cause of a raised pin is fetched from the upper flags
    task automatic service(output logic [7:0] q);
        rd(8'h06, q);
    endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the event flag block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %0t value mismatch", $time); end end
module tb;
    import ifr_pkg::*;
    logic sys_clk, rst_n, reg_wr, reg_rd, pin_a, pin_b;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
    logic [5:0] ev;
    logic [IFR_PTR_W-1:0] wp, rp;
    logic [15:0] bt [12] = '{16'h3305, 16'h3001, 16'h3000, 16'h0003, 16'h5001, 16'h5000,
        16'h6001, 16'h2001, 16'h2000, 16'h1001, 16'h3001, 16'h3000};
    int fail_count, checked;
    ifr_top u_ifr_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .parity_fail_evt(ev[3]), .sample_error_evt(ev[2]), .loop_warning_evt(ev[1]),
        .loop_locked_evt(ev[0]), .sync_lost_evt(ev[5]), .sync_locked_evt(ev[4]),
        .buf_wr_ptr(wp), .buf_rd_ptr(rp), .interrupt_pin_a(pin_a), .interrupt_pin_b(pin_b));
    ifr_host u_ifr_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic wrap_up();
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_ifr_host.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic pulse(input int k);
        @(negedge sys_clk);
        ev[k] = 1'b1;
        @(negedge sys_clk);
        ev[k] = 1'b0;
    endtask
    task automatic wait_pin(input logic b);
        int n;
        n = 0;
        while ((b ? pin_b : pin_a) !== 1'b1) begin
            if (n == 6) begin
                fail_count++;
                wrap_up();
            end
            @(negedge sys_clk);
            n++;
        end
        `CHK((b ? pin_a : pin_b), 1'b0)
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h07, 8'h00);
        u_ifr_host.wr(8'h06, 8'hff);
        rd_chk(8'h06, 8'h00);
        u_ifr_host.wr(8'h07, 8'hff);
        rd_chk(8'h07, 8'h7f);
        rd_chk(8'h20, 8'h00);
        u_ifr_host.wr(8'h07, 8'h00);
    endtask
    task automatic t_route();
        u_ifr_host.wr(8'h04, 8'hf7);
        u_ifr_host.wr(8'h08, 8'h90);
        for (int i = 0; i < 4; i++) begin
            pulse(3 - i);
            wait_pin(((8'h90 >> (7 - i)) & 8'h01) != 8'h00);
            u_ifr_host.service(q);
            `CHK(q, 8'h80 >> i)
            @(negedge sys_clk);
            `CHK(pin_a | pin_b, 1'b0)
        end
        u_ifr_host.wr(8'h04, 8'h00);
    endtask
    task automatic t_sync();
        u_ifr_host.wr(8'h03, 8'h60);
        u_ifr_host.wr(8'h07, 8'h40);
        pulse(5);
        wait_pin(1'b1);
        rd_chk(8'h05, 8'h40);
        pulse(4);
        wait_pin(1'b0);
        rd_chk(8'h05, 8'h20);
        u_ifr_host.wr(8'h03, 8'h00);
    endtask
    // disabled buffer events still flag but leave the pins alone
    task automatic t_buf();
        for (int i = 0; i < 12; i++) begin
            wp = bt[i][14:12];
            rp = bt[i][10:8];
            rd_chk(8'h06, bt[i][7:0]);
            `CHK(pin_a | pin_b, 1'b0)
        end
    endtask
    initial begin
        rst_n = 1'b0;
        ev = 6'h00;
        wp = 3'h3;
        rp = 3'h0;
        fail_count = 0;
        checked = 0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        t_regs();
        t_route();
        t_sync();
        t_buf();
        wrap_up();
    end
endmodule
bind ifr_top ifr_chk u_ifr_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .parity_fail_evt(parity_fail_evt), .sample_error_evt(sample_error_evt),
    .loop_warning_evt(loop_warning_evt), .loop_locked_evt(loop_locked_evt),
    .sync_lost_evt(sync_lost_evt), .sync_locked_evt(sync_locked_evt),
    .buf_wr_ptr(buf_wr_ptr), .buf_rd_ptr(buf_rd_ptr),
    .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b));
